// ---- src/gp_cfg.svh ----
// Constants of the dual GPIO port: register indices, field positions,
// reset values and widths. Assumes byte address = 4 * register index.
`ifndef GP_CFG_SVH
`define GP_CFG_SVH

// Register indices; the APB byte address is four times the index
`define GP_IDX_FIRST_PINS 8'h05
`define GP_IDX_SECOND_PINS 8'h06
`define GP_IDX_INT_CTRL 8'h0B
`define GP_IDX_OPTION 8'h81
`define GP_IDX_FIRST_DIR 8'h85
`define GP_IDX_SECOND_DIR 8'h86
`define GP_IDX_ANALOG_CFG 8'h9F
`define GP_IDX_FIRST_SET 8'hC0
`define GP_IDX_FIRST_CLR 8'hC1
`define GP_IDX_SECOND_SET 8'hC2
`define GP_IDX_SECOND_CLR 8'hC3

// Field positions
`define GP_OPT_PULLUP_N_BIT 7
`define GP_INT_CHANGE_BIT 0
`define GP_TIMER_CLK_BIT 4
`define GP_EXT_INT_BIT 0
`define GP_SLAVE_SEL_BIT 1
`define GP_ANALOG8_BIT 2
`define GP_ANALOG9_BIT 3

// Reset values
`define GP_RST_OPTION 8'hFF
`define GP_RST_FIRST_DIR 6'h3F
`define GP_RST_SECOND_DIR 8'hFF
`define GP_RST_ANALOG_CFG 8'h00
`define GP_RST_LATCH_FIRST 6'h00
`define GP_RST_LATCH_SECOND 8'h00

// Widths, including the synchroniser width
`define GP_FIRST_W 6
`define GP_SECOND_W 8
`define GP_SYNC_W 14
`define GP_ADDR_W 12

`endif

// ---- src/gp_pkg.sv ----
// Types shared by the dual GPIO port modules.
// Assumes gp_cfg.svh is on the include path.
package gp_pkg;
   `include "gp_cfg.svh"

   typedef logic [7:0] gp_byte_t;
   typedef logic [`GP_FIRST_W-1:0] gp_first_t;
   typedef logic [`GP_SYNC_W-1:0] gp_sync_t;

   // Use of an analog-capable first-port pin
   typedef enum logic [1:0] {GP_DIGITAL, GP_ANALOG, GP_VREF} gp_pin_mode_e;
endpackage : gp_pkg

// ---- src/gp_sync_if.sv ----
// Carrier between the port top and its input synchroniser.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface gp_sync_if;
   import gp_pkg::*;
   gp_sync_t raw;
   gp_sync_t synced;
   modport core (output raw, input synced);
   modport sync (input raw, output synced);
endinterface : gp_sync_if

// ---- src/gp_sync.sv ----
// Two-flop synchroniser for the raw pin levels.
// Assumes pins change asynchronously to pclk.
`timescale 1ns/1ps
module gp_sync
   import gp_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pin levels in, synchronised levels out
   gp_sync_if.sync sif
);
   gp_sync_t stage1_reg;
   gp_sync_t stage1_next;
   gp_sync_t stage2_reg;
   gp_sync_t stage2_next;

   // First stage feeds only the second stage, never other logic
   always_comb
   begin
      stage1_next = sif.raw;
      stage2_next = stage1_reg;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stage1_reg <= '0;
         stage2_reg <= '0;
      end
      else
      begin
         stage1_reg <= stage1_next;
         stage2_reg <= stage2_next;
      end
   end

   assign sif.synced = stage2_reg;
endmodule : gp_sync

// ---- src/gp_port.sv ----
// Dual GPIO port with weak pull-ups and change detection, APB slave.
// Assumes pads resolve pin level from out/oe_n and an external pull-up.
// Notes on behaviour
// - First port six bits, or five on small package
// - Direction one tristates, zero drives latch
// - Data read returns pins, write hits latch
// - Set/clear alias writes are read-modify-write of pins
// - First bit 4 timer clock, open-drain low only
// - Analog config selects digital, analog or reference
// - Reset makes analog pins; analog reads zero
// - Enabled peripheral takes pin from GPIO use
// - Second port eight bits, same direction scheme
// - Option bit 7 low enables all pull-ups
// - Pull-up off when pin is an output
// - Pull-ups disabled after power-on reset
// - Second bits 0-3 feed interrupt, select, analog
// - Only input bits 4-7 join change detection
// - Mismatch to last-read value sets change flag
// - Change flag can wake from sleep
// - Port access ends mismatch before flag clear
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "gp_cfg.svh"
module gp_port
   import gp_pkg::*;
#(
   // One for the larger package, zero where first-port bit 5 is absent
   parameter bit WIDE_PACKAGE = 1'b1
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`GP_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // First port pins
   input wire logic [`GP_FIRST_W-1:0] first_pin_in,
   output logic [`GP_FIRST_W-1:0] first_pin_out,
   output logic [`GP_FIRST_W-1:0] first_pin_oe_n,
   // Second port pins
   input wire logic [`GP_SECOND_W-1:0] second_pin_in,
   output logic [`GP_SECOND_W-1:0] second_pin_out,
   output logic [`GP_SECOND_W-1:0] second_pin_oe_n,
   output logic [`GP_SECOND_W-1:0] second_pullup_en,
   // Peripheral side
   input wire logic serial_port_enable,
   output logic timer_clock,
   output logic ext_interrupt,
   output logic slave_select_n,
   output logic lowvolt_in,
   output logic [`GP_FIRST_W-1:0] first_analog_sel,
   output logic [1:0] second_analog_sel,
   // Change event
   output logic pin_change_flag,
   output logic wake_request
);
   // Pin present mask for the package variant
   localparam gp_first_t FIRST_MASK = WIDE_PACKAGE ? 6'h3F : 6'h1F;

   gp_sync_if sif ();

   gp_first_t first_latch_reg;
   gp_first_t first_latch_next;
   gp_first_t first_dir_reg;
   gp_first_t first_dir_next;
   gp_byte_t second_latch_reg;
   gp_byte_t second_latch_next;
   gp_byte_t second_dir_reg;
   gp_byte_t second_dir_next;
   gp_byte_t option_reg;
   gp_byte_t option_next;
   gp_byte_t analog_cfg_reg;
   gp_byte_t analog_cfg_next;
   logic [3:0] last_read_reg;
   logic [3:0] last_read_next;
   logic change_flag_reg;
   logic change_flag_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic slverr_reg;
   logic slverr_next;

   gp_pin_mode_e first_mode [`GP_FIRST_W];
   gp_first_t first_pins;
   gp_first_t first_analog;
   gp_byte_t second_pins;
   logic [7:0] idx;
   logic setup;
   logic wr_access;
   logic mapped;
   logic second_touch;
   logic mismatch;

   // Raw pins enter the synchroniser together
   // synchronise pin inputs
   assign sif.raw = {second_pin_in, first_pin_in};

   gp_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .sif(sif)
   );

   assign second_pins = sif.synced[`GP_SYNC_W-1:`GP_FIRST_W];

   // Analog mode per first-port pin: pins 0,1,2,3,5 are analog-capable.
   // Low config nibble n keeps the first n of them digital; reference
   // bits 4 and 5 pull pins 3 and 2 to reference use.
   // analog config decode
   always_comb
   begin
      logic [2:0] rank;
      rank = 3'd0;
      for (int i = 0; i < `GP_FIRST_W; i++)
      begin
         first_mode[i] = GP_DIGITAL;
         if (i != `GP_TIMER_CLK_BIT)
         begin
            if ({1'b0, rank} >= analog_cfg_reg[3:0])
            begin
               first_mode[i] = GP_ANALOG;
            end
            rank = rank + 3'd1;
         end
      end
      if (analog_cfg_reg[4])
      begin
         first_mode[3] = GP_VREF;
      end
      if (analog_cfg_reg[5])
      begin
         first_mode[2] = GP_VREF;
      end
   end

   // Analog mask and pin view with analog pins reading zero
   always_comb
   begin
      for (int i = 0; i < `GP_FIRST_W; i++)
      begin
         first_analog[i] = (first_mode[i] != GP_DIGITAL);
      end
   end

   assign first_pins = sif.synced[`GP_FIRST_W-1:0] & ~first_analog & FIRST_MASK;
   assign first_analog_sel = first_analog & FIRST_MASK;

   // APB decode; slave answers with zero wait states
   assign idx = paddr[9:2];
   assign setup = psel && !penable;
   assign wr_access = psel && penable && pwrite;
   assign pready = 1'b1;
   assign prdata = rdata_reg;
   assign pslverr = slverr_reg;

   always_comb
   begin
      unique case (idx)
         `GP_IDX_FIRST_PINS, `GP_IDX_SECOND_PINS, `GP_IDX_INT_CTRL,
         `GP_IDX_OPTION, `GP_IDX_FIRST_DIR, `GP_IDX_SECOND_DIR,
         `GP_IDX_ANALOG_CFG, `GP_IDX_FIRST_SET, `GP_IDX_FIRST_CLR,
         `GP_IDX_SECOND_SET, `GP_IDX_SECOND_CLR: mapped = (paddr[11:10] == 2'b00) &&
            (paddr[1:0] == 2'b00);
         default: mapped = 1'b0;
      endcase
   end

   // Read data is captured in the setup cycle, so the pins are sampled once
   // read returns pins
   always_comb
   begin
      rdata_next = rdata_reg;
      slverr_next = 1'b0;
      if (setup)
      begin
         rdata_next = 32'h0000_0000;
         slverr_next = !mapped;
         if (!pwrite && mapped)
         begin
            unique case (idx)
               `GP_IDX_FIRST_PINS: rdata_next[`GP_FIRST_W-1:0] = first_pins;
               `GP_IDX_SECOND_PINS: rdata_next[7:0] = second_pins;
               `GP_IDX_INT_CTRL: rdata_next[`GP_INT_CHANGE_BIT] = change_flag_reg;
               `GP_IDX_OPTION: rdata_next[7:0] = option_reg;
               `GP_IDX_FIRST_DIR: rdata_next[`GP_FIRST_W-1:0] = first_dir_reg & FIRST_MASK;
               `GP_IDX_SECOND_DIR: rdata_next[7:0] = second_dir_reg;
               `GP_IDX_ANALOG_CFG: rdata_next[7:0] = analog_cfg_reg;
               default: rdata_next = 32'h0000_0000;
            endcase
         end
      end
   end

   // Register writes take effect at the access edge.
   // Set/clear aliases let software change a few bits; the untouched
   // bits are refilled from the pins; a plain port write takes pwdata whole.
   // read-modify-write writes
   always_comb
   begin
      first_latch_next = first_latch_reg;
      first_dir_next = first_dir_reg;
      second_latch_next = second_latch_reg;
      second_dir_next = second_dir_reg;
      option_next = option_reg;
      analog_cfg_next = analog_cfg_reg;
      if (wr_access && mapped)
      begin
         unique case (idx)
            `GP_IDX_FIRST_PINS: first_latch_next = pwdata[`GP_FIRST_W-1:0] & FIRST_MASK;
            `GP_IDX_SECOND_PINS: second_latch_next = pwdata[7:0];
            `GP_IDX_FIRST_SET:
               first_latch_next = (first_pins | pwdata[`GP_FIRST_W-1:0]) & FIRST_MASK;
            `GP_IDX_FIRST_CLR:
               first_latch_next = first_pins & ~pwdata[`GP_FIRST_W-1:0] & FIRST_MASK;
            `GP_IDX_SECOND_SET: second_latch_next = second_pins | pwdata[7:0];
            `GP_IDX_SECOND_CLR: second_latch_next = second_pins & ~pwdata[7:0];
            `GP_IDX_OPTION: option_next = pwdata[7:0];
            `GP_IDX_FIRST_DIR: first_dir_next = pwdata[`GP_FIRST_W-1:0] | ~FIRST_MASK;
            `GP_IDX_SECOND_DIR: second_dir_next = pwdata[7:0];
            `GP_IDX_ANALOG_CFG: analog_cfg_next = pwdata[7:0];
            default: first_latch_next = first_latch_reg;
         endcase
      end
   end

   // Change detection on the upper nibble of the second port.
   // Output pins are masked out of the comparison.
   // input-only comparison
   assign mismatch = |((second_pins[7:4] ^ last_read_reg) & second_dir_reg[7:4]);

   // Any read or write of the second port reloads the reference nibble
   // access ends mismatch
   assign second_touch = setup && mapped && (idx == `GP_IDX_SECOND_PINS ||
      idx == `GP_IDX_SECOND_SET || idx == `GP_IDX_SECOND_CLR);

   always_comb
   begin
      last_read_next = last_read_reg;
      if (second_touch)
      begin
         last_read_next = second_pins[7:4];
      end
   end

   // Flag: a live mismatch sets it and wins over a software clear,
   // so software must end the mismatch before clearing
   // mismatch sets flag
   always_comb
   begin
      change_flag_next = change_flag_reg;
      if (wr_access && mapped && idx == `GP_IDX_INT_CTRL)
      begin
         change_flag_next = pwdata[`GP_INT_CHANGE_BIT];
      end
      if (mismatch)
      begin
         change_flag_next = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         first_latch_reg <= `GP_RST_LATCH_FIRST;
         first_dir_reg <= `GP_RST_FIRST_DIR;
         second_latch_reg <= `GP_RST_LATCH_SECOND;
         second_dir_reg <= `GP_RST_SECOND_DIR;
         option_reg <= `GP_RST_OPTION;
         analog_cfg_reg <= `GP_RST_ANALOG_CFG;
         last_read_reg <= 4'h0;
         change_flag_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         slverr_reg <= 1'b0;
      end
      else
      begin
         first_latch_reg <= first_latch_next;
         first_dir_reg <= first_dir_next;
         second_latch_reg <= second_latch_next;
         second_dir_reg <= second_dir_next;
         option_reg <= option_next;
         analog_cfg_reg <= analog_cfg_next;
         last_read_reg <= last_read_next;
         change_flag_reg <= change_flag_next;
         rdata_reg <= rdata_next;
         slverr_reg <= slverr_next;
      end
   end

   // First-port drivers; bit 4 only sinks, so it drives a low only
   // when the latch holds zero. Absent bit 5 never drives.
   // direction controls driver
   always_comb
   begin
      first_pin_out = first_latch_reg;
      first_pin_oe_n = first_dir_reg | ~FIRST_MASK;
      first_pin_out[`GP_TIMER_CLK_BIT] = 1'b0;
      first_pin_oe_n[`GP_TIMER_CLK_BIT] = first_dir_reg[`GP_TIMER_CLK_BIT] ||
         first_latch_reg[`GP_TIMER_CLK_BIT];
   end

   // Second-port drivers; an enabled serial port owns the select pin,
   // which is then held as an input regardless of its direction bit
   // peripheral takes pin
   always_comb
   begin
      second_pin_out = second_latch_reg;
      second_pin_oe_n = second_dir_reg;
      if (serial_port_enable)
      begin
         second_pin_oe_n[`GP_SLAVE_SEL_BIT] = 1'b1;
      end
   end

   // Weak pull-ups: global active-low enable, off on output pins
   // global pull-up enable
   assign second_pullup_en = {8{!option_reg[`GP_OPT_PULLUP_N_BIT]}} & second_dir_reg;

   // Alternate functions fed from synchronised pins; second-port analog selects from direction bits 2-3
   // first- and second-port shared functions
   assign timer_clock = sif.synced[`GP_TIMER_CLK_BIT];
   assign ext_interrupt = second_pins[`GP_EXT_INT_BIT];
   assign slave_select_n = serial_port_enable ? second_pins[`GP_SLAVE_SEL_BIT] : 1'b1;
   assign lowvolt_in = second_pins[`GP_ANALOG9_BIT];
   assign second_analog_sel = second_dir_reg[`GP_ANALOG9_BIT:`GP_ANALOG8_BIT];

   // Flag is a level; the sleep controller may use it as a wake source
   // change wakes device
   assign pin_change_flag = change_flag_reg;
   assign wake_request = change_flag_reg;
endmodule : gp_port

// ---- bench/gp_port_monitor.sv ----
// Checker for the dual GPIO port, bound into every gp_port.
// Assumes one clock pclk and the async active-low presetn.
`timescale 1ns/1ps
module gp_port_monitor
   import gp_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // Pins
   input wire logic [5:0] first_pin_in,
   input wire logic [5:0] first_pin_out,
   input wire logic [7:0] second_pin_oe_n,
   input wire logic [7:0] second_pullup_en,
   // Peripheral side
   input wire logic serial_port_enable,
   input wire logic timer_clock,
   input wire logic slave_select_n,
   input wire logic pin_change_flag,
   input wire logic wake_request
);
   logic [1:0] up_reg;
   logic [1:0] up_next;

   // Edges since reset; the synchroniser shows reset zeros for two edges
   always_comb
      up_next = (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         up_reg <= 2'h0;
      else
         up_reg <= up_next;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // APB setup and the access cycle after it
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence

   a_refused_zero: assert property (
      s_setup ##1 (s_access and pslverr) |-> prdata == 32'h0)
      else $error("refused access returned data");
   a_flag_clear_write: assert property (
      $fell(pin_change_flag) |-> $past(psel) && $past(penable) && $past(pwrite))
      else $error("change flag cleared without a write");
   a_timer_open_drain: assert property (first_pin_out[4] == 1'b0)
      else $error("timer pin driven high");
   a_pullup_input_only: assert property ((second_pullup_en & ~second_pin_oe_n) == 8'h00)
      else $error("pull-up on a driven pin");
   a_pullup_common: assert property (
      !serial_port_enable && second_pullup_en != 8'h00 |-> second_pullup_en == second_pin_oe_n)
      else $error("pull-ups not switched together");
   a_wake_follows_flag: assert property (wake_request == pin_change_flag)
      else $error("wake differs from change flag");
   a_serial_owns_pin: assert property (serial_port_enable |-> second_pin_oe_n[1])
      else $error("port drives the select pin");
   a_select_idle_high: assert property (!serial_port_enable |-> slave_select_n)
      else $error("select active while serial port off");
   a_timer_two_flop: assert property (
      up_reg == 2'h3 |-> timer_clock == $past(first_pin_in[4], 2))
      else $error("timer input not two edges late");
endmodule : gp_port_monitor

bind gp_port gp_port_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .prdata,
   .pslverr, .first_pin_in, .first_pin_out, .second_pin_oe_n, .second_pullup_en,
   .serial_port_enable, .timer_clock, .slave_select_n, .pin_change_flag, .wake_request);

// ---- bench/gp_pads.sv ----
// Board model: resolves each pad from device drive, board drive and pull-up.
// Assumes the board drives every free first-port pad.
`timescale 1ns/1ps
module gp_pads
(
   // Clock
   input wire logic pclk,
   // Device pad controls
   input wire logic [5:0] first_pin_out,
   input wire logic [5:0] first_pin_oe_n,
   input wire logic [7:0] second_pin_out,
   input wire logic [7:0] second_pin_oe_n,
   input wire logic [7:0] second_pullup_en,
   // Board drive and its enables
   input wire logic [5:0] first_ext,
   input wire logic [7:0] second_ext,
   input wire logic [7:0] second_ext_drv,
   // Levels seen by the device
   output logic [5:0] first_pin_in,
   output logic [7:0] second_pin_in
);
   logic float_reg = 1'b0;

   // An undriven pad wanders, so a stale level never passes
   always_ff @(posedge pclk)
      float_reg <= !float_reg;

   // device drive wins over the board
   assign first_pin_in = (first_pin_oe_n & first_ext) | (~first_pin_oe_n & first_pin_out);
   // pull-up holds only a free pad
   assign second_pin_in = (~second_pin_oe_n & second_pin_out)
      | (second_pin_oe_n & second_ext_drv & second_ext)
      | (second_pin_oe_n & ~second_ext_drv & (second_pullup_en | {8{float_reg}}));
endmodule : gp_pads

// ---- bench/gp_port_tb.sv ----
// Self-checking bench for gp_port: APB master, board model, random pin levels.
// Assumes gp_port_monitor is bound into the design.
`timescale 1ns/1ps
module gp_port_tb
   import gp_pkg::*;
;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic serial_port_enable = 1'b0;
   gp_first_t first_ext = 6'h00;
   gp_byte_t second_ext = 8'h00, second_ext_drv = 8'hFF;
   logic [31:0] prdata, rd_data;
   logic pready, pslverr, rd_err, slave_select_n, pin_change_flag;
   logic ext_interrupt, lowvolt_in;
   logic [1:0] second_analog_sel;
   gp_first_t first_pin_in, first_pin_out, first_pin_oe_n, first_analog_sel;
   gp_byte_t second_pin_in, second_pin_out, second_pin_oe_n, second_pullup_en;
   logic [15:0] lfsr_state = 16'hFE15;
   int errors = 0;
   int cmp_count = 0;

   // 50 MHz clock
   initial
      forever #10 pclk = ~pclk;

   gp_port DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .first_pin_in, .first_pin_out, .first_pin_oe_n, .second_pin_in,
      .second_pin_out, .second_pin_oe_n, .second_pullup_en, .serial_port_enable,
      .timer_clock(), .ext_interrupt, .slave_select_n, .lowvolt_in,
      .first_analog_sel, .second_analog_sel, .pin_change_flag, .wake_request());
   gp_pads u_pads (.pclk, .first_pin_out, .first_pin_oe_n, .second_pin_out,
      .second_pin_oe_n, .second_pullup_en, .first_ext, .second_ext, .second_ext_drv,
      .first_pin_in, .second_pin_in);

   // Analog pins read zero: rank of pins 0,1,2,3,5 against the config field
   function automatic gp_first_t exp_first(input gp_byte_t cfg, input gp_first_t p);
      return p & ~{cfg[3:0] <= 4'h4, 1'b0, cfg[3:0] <= 4'h3, cfg[3:0] <= 4'h2,
         cfg[3:0] <= 4'h1, cfg[3:0] == 4'h0};
   endfunction : exp_first

   // Set and clear aliases modify the sampled pins
   function automatic gp_byte_t exp_rmw(input logic set, input gp_byte_t p, input gp_byte_t w);
      return set ? (p | w) : (p & ~w);
   endfunction : exp_rmw

   // Maximal-length shift register; fixed start keeps runs repeatable
   function automatic gp_byte_t rnd();
      lfsr_state = {lfsr_state[14:0], lfsr_state[15] ^ lfsr_state[13] ^ lfsr_state[12]
         ^ lfsr_state[10]};
      return lfsr_state[7:0];
   endfunction : rnd

   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; holds the request until pready is seen high
   task automatic apb(input logic wr, input gp_byte_t idx, input gp_byte_t wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
         n++;
         if (n > 16)
         begin
            errors++;
            complete_run();
         end
         @(posedge pclk);
      end
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input gp_byte_t idx, input gp_byte_t wd);
      apb(1'b1, idx, wd);
   endtask : wr

   task automatic rdc(input gp_byte_t idx, input gp_byte_t exp, input logic err);
      apb(1'b0, idx, 8'h00);
      chk(rd_data, {24'h0, exp});
      chk({31'h0, rd_err}, {31'h0, err});
   endtask : rdc

   // New second-port levels, then the change flag once they have crossed
   task automatic flag_chk(input gp_byte_t v, input logic f);
      @(posedge pclk);
      second_ext <= v;
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      chk({31'h0, pin_change_flag}, {31'h0, f});
   endtask : flag_chk

   // Main sequence
   initial
   begin
      gp_byte_t v, w;
      int k;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      v = rnd();
      first_ext <= v[5:0] | 6'h01;
      rdc(8'h81, 8'hFF, 1'b0);
      rdc(8'h86, 8'hFF, 1'b0);
      rdc(8'h85, 8'h3F, 1'b0);
      rdc(8'h9F, 8'h00, 1'b0);
      chk({24'h0, second_pullup_en}, 32'h0);
      // analog pins keep their reset input direction
      for (k = 0; k < 6; k++)
      begin
         wr(8'h9F, k[7:0]);
         rdc(8'h05, {2'b00, exp_first(k[7:0], first_ext)}, 1'b0);
         chk({26'h0, first_analog_sel}, {26'h0, ~exp_first(k[7:0], 6'h3F)});
      end
      wr(8'h85, 8'h00);
      wr(8'h05, 8'h10);
      @(negedge pclk);
      chk({26'h0, first_pin_oe_n}, 32'h10);
      repeat (2) @(posedge pclk);
      rdc(8'h05, {2'b00, first_ext & 6'h10}, 1'b0);
      wr(8'h05, 8'h00);
      @(negedge pclk);
      chk({26'h0, first_pin_oe_n}, 32'h00);
      for (k = 0; k < 4; k++)
      begin
         v = rnd();
         w = rnd();
         @(posedge pclk);
         second_ext <= (k == 0) ? 8'hFF : v;
         repeat (3) @(posedge pclk);
         wr(k[0] ? 8'hC3 : 8'hC2, w);
         @(negedge pclk);
         chk({24'h0, second_pin_out}, {24'h0, exp_rmw(!k[0], second_ext, w)});
      end
      wr(8'h06, 8'hA5);
      @(negedge pclk);
      chk({24'h0, second_pin_out}, 32'hA5);
      rdc(8'h06, second_ext, 1'b0);
      wr(8'h86, 8'h00);
      @(posedge pclk);
      second_ext <= 8'h00;
      serial_port_enable <= 1'b1;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk({24'h0, second_pin_oe_n}, 32'h02);
      chk({31'h0, slave_select_n}, 32'h0);
      // Driven latch 0xA5 shows on the shared pins; all direction bits are zero
      chk({28'h0, second_analog_sel, ext_interrupt, lowvolt_in}, 32'h2);
      @(posedge pclk);
      serial_port_enable <= 1'b0;
      wr(8'h86, 8'hF0);
      wr(8'h81, 8'h7F);
      second_ext_drv <= 8'h00;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk({24'h0, second_pullup_en}, 32'hF0);
      rdc(8'h06, 8'hF5, 1'b0);
      second_ext_drv <= 8'hFF;
      wr(8'h81, 8'hFF);
      wr(8'h86, 8'hFF);
      @(negedge pclk);
      chk({24'h0, second_pullup_en}, 32'h00);
      // Earlier pin traffic left the flag set: read the port, then clear it
      repeat (2) @(posedge pclk);
      rdc(8'h06, 8'h00, 1'b0);
      wr(8'h0B, 8'h00);
      rdc(8'h0B, 8'h00, 1'b0);
      // the flag is watched without polling the port
      flag_chk(8'h50, 1'b1);
      rdc(8'h06, 8'h50, 1'b0);
      wr(8'h0B, 8'h00);
      flag_chk(8'h52, 1'b0);
      flag_chk(8'h70, 1'b1);
      wr(8'h0B, 8'h00);
      rdc(8'h0B, 8'h01, 1'b0);
      rdc(8'h06, 8'h70, 1'b0);
      wr(8'h0B, 8'h00);
      rdc(8'h0B, 8'h00, 1'b0);
      wr(8'h06, 8'h00);
      wr(8'h86, 8'hBF);
      flag_chk(8'h70, 1'b0);
      wr(8'h10, 8'hFF);
      rdc(8'h10, 8'h00, 1'b1);
      complete_run();
   end
endmodule : gp_port_tb
